// ---- src/rsc_pkg.sv ----
package rsc_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 4;

  // external reset pin minimum low width (ns) and its cycle count, rounded up
  localparam int unsigned EXT_MIN_PULSE_NS  = 400;
  localparam int unsigned EXT_MIN_PULSE_CYC =
    (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // brown-out minimum dip width (ns); not printed, plain default
  localparam int unsigned BROWNOUT_MIN_DIP_NS  = 40;
  localparam int unsigned BROWNOUT_MIN_DIP_CYC =
    (BROWNOUT_MIN_DIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned FILT_W = 8;

  // stretch counter
  localparam int unsigned STRETCH_W = 20;
  localparam int unsigned STRETCH_SEL_W = 2;

  // stretch lengths per selection code (startup-time fuse xor clock-source fuse), in cycles
  localparam logic [STRETCH_W-1:0] STRETCH_CYC_0 = 20'h00010;
  localparam logic [STRETCH_W-1:0] STRETCH_CYC_1 = 20'h00400;
  localparam logic [STRETCH_W-1:0] STRETCH_CYC_2 = 20'h04000;
  localparam logic [STRETCH_W-1:0] STRETCH_CYC_3 = 20'hfa000;

  // brown-out fuse codes
  localparam logic [2:0] BOD_LEVEL_OFF     = 3'h7;
  localparam logic [2:0] BOD_LEVEL_HIGHEST = 3'h0;

  // cause flag positions
  localparam int unsigned FLAG_W    = 6;
  localparam int unsigned FLAG_POR  = 0;
  localparam int unsigned FLAG_EXT  = 1;
  localparam int unsigned FLAG_BOD  = 2;
  localparam int unsigned FLAG_WDT  = 3;
  localparam int unsigned FLAG_SCAN = 4;
  localparam int unsigned FLAG_USB  = 5;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 6'h00;

  // raw reset requests, grouped
  typedef struct packed {
    logic usb_end;
    logic scan;
    logic wdt;
    logic brownout_detector;
    logic ext;
    logic por;
  } rsc_req_t;

  typedef enum logic [1:0] {
    RSC_HOLD,
    RSC_STRETCH,
    RSC_RUN
  } rsc_state_t;

  // stretch length for a fuse selection
  function automatic logic [STRETCH_W-1:0] rsc_stretch_len(input logic [1:0] sel);
    case (sel)
      2'h0:    rsc_stretch_len = STRETCH_CYC_0;
      2'h1:    rsc_stretch_len = STRETCH_CYC_1;
      2'h2:    rsc_stretch_len = STRETCH_CYC_2;
      default: rsc_stretch_len = STRETCH_CYC_3;
    endcase
  endfunction

endpackage

// ---- src/rsc_sync.sv ----
`timescale 1ns/10ps
module rsc_sync import rsc_pkg::*; #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // reset value must be constant at the instance; no async path here
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      meta_r <= rst_val_in;
      q_r    <= rst_val_in;
    end else begin
      meta_r <= d_in;
      q_r    <= meta_r;
    end
  end

  assign q_out = q_r;
endmodule // rsc_sync

// ---- src/rsc_filt.sv ----
`timescale 1ns/10ps
module rsc_filt import rsc_pkg::*; (
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              level_in,
  input  wire logic [FILT_W-1:0] min_cyc_in,
  output logic                   qual_out
);
  logic [FILT_W-1:0] cnt_r;
  logic [FILT_W-1:0] cnt_nxt;
  logic              qual_r;
  wire               reached = (cnt_r >= min_cyc_in);

  assign cnt_nxt = !level_in ? '0 : (reached ? cnt_r : cnt_r + 1'b1);

  // a level counts only once it has lasted past the minimum width
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      qual_r <= level_in && reached;
    end
  end

  assign qual_out = qual_r;
endmodule // rsc_filt

// ---- src/rsc_ctrl.sv ----
`timescale 1ns/10ps
// Functional notes
// [R1] internal reset resets all I/O registers; fetch begins at reset vector after release
// [R2] any active source forces port hold at once, without a clock; code does so only for por, ext, enabled brown-out and scan
// [R3] after all sources drop, stretch reset by fuse-selected count
// [R4] power-on request resets whenever supply is low, reasserting immediately
// [R5] external pin low longer than minimum width causes reset
// [R6] external pin rising starts stretch; release only after full time-out
// [R7] watchdog expiry resets when enabled in reset mode
// [R8] brown-out fuse code 111 disables, lower codes enable higher levels
// [R9] brown-out drop resets at once; recovery starts stretch
// [R10] brown-out dips shorter than minimum width are ignored
// [R11] scan-chain reset bit holds processor in reset while set
// [R12] enabled usb end-of-reset resets the core, usb stays attached
// [R13] watchdog expiry gives one-cycle pulse; stretch starts after it
// [R14] each cause sets its flag; por clears others; writing zero clears
// [R15] internal reset is or of requests and stretch, released synchronously
module rsc_ctrl import rsc_pkg::*; (
  input  wire logic                     sys_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic                     por_req_in,
  input  wire logic                     ext_rst_n_in,
  input  wire logic                     wdt_expire_in,
  input  wire logic                     wdt_reset_mode_in,
  input  wire logic                     bod_low_in,
  input  wire logic [2:0]               brownout_level_fuse_in,
  input  wire logic                     scan_rst_bit_in,
  input  wire logic                     usb_end_rst_in,
  input  wire logic                     usb_rst_en_in,
  input  wire logic [1:0]               startup_time_fuse_in,
  input  wire logic [1:0]               clock_source_fuse_in,
  input  wire logic                     flag_wr_in,
  input  wire logic [FLAG_W-1:0]        flag_wdata_in,
  output logic                          port_hold_out,
  output logic                          core_rst_out,
  output logic                          fetch_vec_out,
  output logic                          usb_keep_out,
  output logic                          brownout_detector_en_out,
  output logic [FLAG_W-1:0]             cause_flags_out
);
  rsc_req_t          sync_q;
  rsc_req_t          raw;
  rsc_req_t          req;
  logic              bod_qual;
  logic              ext_qual;
  rsc_state_t        state_r;
  rsc_state_t        state_nxt;
  logic [STRETCH_W-1:0] cnt_r;
  logic [STRETCH_W-1:0] cnt_nxt;
  logic              wdt_prev_r;
  logic              hold_r;
  logic              core_rst_r;
  logic              fetch_r;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] set_vec;
  logic              bod_en_r;
  logic              usb_keep_r;

  // pins and foreign levels, two flops each before the request logic uses them
  assign raw.por     = por_req_in;
  assign raw.ext     = ~ext_rst_n_in;
  assign raw.wdt     = wdt_expire_in;
  assign raw.brownout_detector     = bod_low_in;
  assign raw.scan    = scan_rst_bit_in;
  assign raw.usb_end = usb_end_rst_in;

  rsc_sync #(.W($bits(rsc_req_t))) u_sync (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (raw),
    .rst_val_in ('0),
    .q_out      (sync_q)
  );

  rsc_filt u_ext_filt (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (sync_q.ext),
    .min_cyc_in (FILT_W'(EXT_MIN_PULSE_CYC)),
    .qual_out   (ext_qual)
  );

  rsc_filt u_bod_filt (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (sync_q.brownout_detector & bod_en_r),
    .min_cyc_in (FILT_W'(BROWNOUT_MIN_DIP_CYC)),
    .qual_out   (bod_qual)
  );

  wire bod_en   = (brownout_level_fuse_in != BOD_LEVEL_OFF); // [R8]
  wire wdt_edge = sync_q.wdt & ~wdt_prev_r & wdt_reset_mode_in; // [R7] [R13]

  assign req.por     = sync_q.por;                       // [R4]
  assign req.ext     = ext_qual;                         // [R5]
  assign req.wdt     = wdt_edge;                         // [R13]
  assign req.brownout_detector     = bod_qual;                         // [R9] [R10]
  assign req.scan    = sync_q.scan;                      // [R11]
  assign req.usb_end = sync_q.usb_end & usb_rst_en_in;   // [R12]

  wire any_req = |req;
  wire [STRETCH_W-1:0] stretch_len =
    rsc_stretch_len(startup_time_fuse_in ^ clock_source_fuse_in); // [R3]
  // the raw pin/supply level drives the hold directly: no clock needed there
  wire async_hold = raw.por | raw.ext | (raw.brownout_detector & bod_en) | raw.scan; // [R2]

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      RSC_HOLD: begin
        if (!any_req) begin
          state_nxt = RSC_STRETCH; // [R3] [R6] [R9]
          cnt_nxt   = stretch_len;
        end
      end
      RSC_STRETCH: begin
        if (any_req) begin
          state_nxt = RSC_HOLD; // [R4]
        end else if (cnt_r <= 20'h00001) begin
          state_nxt = RSC_RUN; // [R6]
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      RSC_RUN: begin
        if (any_req) begin
          state_nxt = RSC_HOLD;
        end
      end
      default: state_nxt = RSC_HOLD;
    endcase
  end

  // causes: por clears the others; set wins over a software zero write
  assign set_vec = {req.usb_end, req.scan, req.wdt, req.brownout_detector, req.ext, req.por};
  always_comb begin
    flags_nxt = flags_r;
    if (flag_wr_in) begin
      flags_nxt = flags_r & flag_wdata_in; // [R14]
    end
    if (req.por) begin
      flags_nxt = FLAG_RESET; // [R14]
    end
    flags_nxt = flags_nxt | set_vec; // [R14]
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_r    <= RSC_HOLD;
      cnt_r      <= '0;
      wdt_prev_r <= 1'b0;
      core_rst_r <= 1'b1;
      fetch_r    <= 1'b0;
      flags_r    <= FLAG_RESET;
      bod_en_r   <= 1'b0;
      usb_keep_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      wdt_prev_r <= sync_q.wdt;
      core_rst_r <= (state_nxt != RSC_RUN); // [R15] [R1]
      fetch_r    <= (state_nxt == RSC_RUN) && (state_r != RSC_RUN); // [R1]
      flags_r    <= flags_nxt;
      bod_en_r   <= bod_en;
      // usb side stays attached whatever reset the core takes
      usb_keep_r <= 1'b1; // [R12]
    end
  end

  // port hold set asynchronously by raw por, ext, enabled brown-out or scan, released on the clock
  always_ff @(posedge sys_clk_in or posedge async_hold) begin
    if (async_hold) begin
      hold_r <= 1'b1; // [R2]
    end else if (sys_rst_in) begin
      hold_r <= 1'b1;
    end else begin
      hold_r <= (state_nxt != RSC_RUN); // [R1]
    end
  end

  assign port_hold_out            = hold_r;
  assign core_rst_out             = core_rst_r;
  assign fetch_vec_out            = fetch_r;
  assign usb_keep_out             = usb_keep_r; // [R12]
  assign brownout_detector_en_out = bod_en_r;
  assign cause_flags_out          = flags_r;

  // assertions
  a_hold_tracks_reset: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    core_rst_r |-> hold_r) else $error("port hold dropped during reset"); // [R2]
  a_release_after_stretch: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == RSC_STRETCH && !any_req && cnt_r > 20'h00001) |=> core_rst_r)
    else $error("reset released before stretch ended"); // [R3]
  a_por_immediate: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req.por |=> (state_r == RSC_HOLD) && core_rst_r) else $error("por did not reassert"); // [R4]
  a_ext_qualifies: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ext_qual |=> state_r == RSC_HOLD) else $error("external reset ignored"); // [R5]
  a_stretch_starts: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (state_r == RSC_HOLD && !any_req) |=> state_r == RSC_STRETCH && cnt_r == $past(stretch_len))
    else $error("stretch did not start"); // [R6]
  a_wdt_one_cycle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req.wdt |=> !req.wdt) else $error("watchdog pulse longer than one cycle"); // [R13]
  a_bod_disabled: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (brownout_level_fuse_in == BOD_LEVEL_OFF) [*3] |-> !bod_qual)
    else $error("brown-out active while disabled"); // [R8]
  a_scan_holds: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req.scan |=> core_rst_r) else $error("scan reset not held"); // [R11]
  a_flag_set_wins: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (req.ext && flag_wr_in) |=> flags_r[FLAG_EXT]) else $error("cause flag lost"); // [R14]
  a_usb_gated: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !usb_rst_en_in |-> !req.usb_end) else $error("usb reset while disabled"); // [R12]
endmodule // rsc_ctrl

// ---- dv/rsc_src_model.sv ----
`timescale 1ns/10ps
module rsc_src_model import rsc_pkg::*; (
  input  wire logic sys_clk_in,
  output logic      por_req_out,
  output logic      ext_rst_n_out,
  output logic      wdt_expire_out,
  output logic      bod_low_out,
  output logic      scan_rst_bit_out,
  output logic      usb_end_rst_out
);
  initial begin
    {por_req_out, wdt_expire_out, bod_low_out, scan_rst_bit_out, usb_end_rst_out} = 5'h00;
    ext_rst_n_out = 1'b1;
  end
  // sources are levels, moved only at the falling edge
  task automatic set_src(input int unsigned idx, input logic v);
    @(negedge sys_clk_in);
    case (idx)
      FLAG_POR:  por_req_out = v;
      FLAG_EXT:  ext_rst_n_out = ~v;
      FLAG_BOD:  bod_low_out = v;
      FLAG_WDT:  wdt_expire_out = v;
      FLAG_SCAN: scan_rst_bit_out = v;
      default:   usb_end_rst_out = v;
    endcase
  endtask
endmodule // rsc_src_model

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb import rsc_pkg::*;;
  logic       clk, rst, wdt_mode, usb_en, flag_wr;
  logic [2:0] bod_fuse;
  logic [1:0] startup_time_fuse, cks;
  logic [5:0] flag_wdata, flags;
  logic       por, ext_n, wdt, brownout_detector, scan, usb;
  logic       hold, core_rst, fetch, keep, bod_en;
  int         error_cnt = 0;
  int         cmp_count = 0;

  rsc_src_model i_src (.sys_clk_in(clk), .por_req_out(por), .ext_rst_n_out(ext_n),
    .wdt_expire_out(wdt), .bod_low_out(brownout_detector), .scan_rst_bit_out(scan),
    .usb_end_rst_out(usb));
  rsc_ctrl i_dut (.sys_clk_in(clk), .sys_rst_in(rst), .por_req_in(por),
    .ext_rst_n_in(ext_n), .wdt_expire_in(wdt), .wdt_reset_mode_in(wdt_mode),
    .bod_low_in(brownout_detector), .brownout_level_fuse_in(bod_fuse), .scan_rst_bit_in(scan),
    .usb_end_rst_in(usb), .usb_rst_en_in(usb_en), .startup_time_fuse_in(startup_time_fuse),
    .clock_source_fuse_in(cks), .flag_wr_in(flag_wr), .flag_wdata_in(flag_wdata),
    .port_hold_out(hold), .core_rst_out(core_rst), .fetch_vec_out(fetch),
    .usb_keep_out(keep), .brownout_detector_en_out(bod_en), .cause_flags_out(flags));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    $display("tests done: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // wait for release; lo..hi is the allowed count after the source drops
  task automatic wait_rel(input int lo, input int hi);
    int c;
    c = 0;
    while (core_rst === 1'b1 && c < 20000) begin
      @(negedge clk);
      c++;
    end
    `CHK("release_len", 1'b1, (c >= lo && c <= hi))
    `CHK("fetch_pulse", 1'b1, fetch)
    `CHK("hold_free", 1'b0, hold)
    @(negedge clk);
    `CHK("fetch_once", 1'b0, fetch)
  endtask

  // one source held n cycles; hit tells whether a reset must follow
  task automatic pulse(input int unsigned src, input int n, input logic hit, input int lo);
    i_src.set_src(src, 1'b1);
    #1;
    if (hit && src != FLAG_WDT && src != FLAG_USB) `CHK("port_hold", 1'b1, hold)
    repeat (n - 1) @(negedge clk);
    `CHK("core_rst_on", hit, core_rst)
    i_src.set_src(src, 1'b0);
    if (hit) begin
      wait_rel(lo, lo + 6);
      `CHK("cause_flag", 1'b1, flags[src])
    end else begin
      repeat (8) @(negedge clk);
      `CHK("no_reset", 1'b0, core_rst)
    end
  endtask

  task automatic t_ext();
    pulse(FLAG_EXT, 120, 1'b1, 16);
    $display("t_ext done");
  endtask

  task automatic t_bod();
    // the enable is registered: look one edge after the fuse moves
    bod_fuse = BOD_LEVEL_OFF;
    @(negedge clk);
    `CHK("bod_en_off", 1'b0, bod_en)
    pulse(FLAG_BOD, 30, 1'b0, 0);
    bod_fuse = 3'h6;
    @(negedge clk);
    `CHK("bod_en_6", 1'b1, bod_en)
    bod_fuse = BOD_LEVEL_HIGHEST;
    @(negedge clk);
    `CHK("bod_en_0", 1'b1, bod_en)
    pulse(FLAG_BOD, 3, 1'b0, 0);
    pulse(FLAG_BOD, 20, 1'b1, 16);
    $display("t_bod done");
  endtask

  task automatic t_wdt();
    wdt_mode = 1'b0;
    pulse(FLAG_WDT, 8, 1'b0, 0);
    wdt_mode = 1'b1;
    pulse(FLAG_WDT, 6, 1'b1, 8);
    $display("t_wdt done");
  endtask

  task automatic t_scan_usb();
    pulse(FLAG_SCAN, 300, 1'b1, 16);
    usb_en = 1'b0;
    pulse(FLAG_USB, 8, 1'b0, 0);
    usb_en = 1'b1;
    pulse(FLAG_USB, 8, 1'b1, 16);
    `CHK("usb_keep", 1'b1, keep)
    $display("t_scan_usb done");
  endtask

  task automatic t_por_flags();
    pulse(FLAG_POR, 8, 1'b1, 16);
    `CHK("por_flags", 6'h01, flags)
    flag_wdata = 6'h00;
    flag_wr = 1'b1;
    @(negedge clk);
    flag_wr = 1'b0;
    @(negedge clk);
    `CHK("flags_clr", 6'h00, flags)
    // zero write while the external cause is still active: the set wins
    i_src.set_src(FLAG_EXT, 1'b1);
    repeat (110) @(negedge clk);
    flag_wr = 1'b1;
    @(negedge clk);
    flag_wr = 1'b0;
    `CHK("flag_set_wins", 6'h02, flags)
    i_src.set_src(FLAG_EXT, 1'b0);
    wait_rel(16, 22);
    $display("t_por_flags done");
  endtask

  task automatic t_sel();
    startup_time_fuse = 2'h1;
    cks = 2'h1;
    pulse(FLAG_EXT, 110, 1'b1, 16);
    cks = 2'h0;
    pulse(FLAG_EXT, 110, 1'b1, 1024);
    cks = 2'h3;
    pulse(FLAG_EXT, 110, 1'b1, 16384);
    startup_time_fuse = 2'h3;
    cks = 2'h0;
    i_src.set_src(FLAG_EXT, 1'b1);
    repeat (110) @(negedge clk);
    i_src.set_src(FLAG_EXT, 1'b0);
    // longest stretch is too long to wait out; it must outlast the next one
    repeat (17000) @(negedge clk);
    `CHK("long_stretch", 1'b1, core_rst)
    $display("t_sel done");
  endtask

  // reset in mid-stretch, then a clean restart on the shortest stretch
  task automatic t_rerst();
    {startup_time_fuse, cks} = 4'h0;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("rerst_core", 1'b1, core_rst)
    `CHK("rerst_hold", 1'b1, hold)
    `CHK("rerst_flags", FLAG_RESET, flags)
    rst = 1'b0;
    wait_rel(16, 24);
    $display("t_rerst done");
  endtask

  initial begin
    rst = 1'b1;
    {wdt_mode, usb_en, flag_wr, startup_time_fuse, cks} = 7'h00;
    bod_fuse = BOD_LEVEL_OFF;
    flag_wdata = 6'h3f;
    repeat (8) @(negedge clk);
    `CHK("rst_core", 1'b1, core_rst)
    `CHK("rst_flags", FLAG_RESET, flags)
    rst = 1'b0;
    wait_rel(16, 24);
    t_ext();
    t_bod();
    t_wdt();
    t_scan_usb();
    t_por_flags();
    t_sel();
    t_rerst();
    stop_test();
  end

  // about 36000 cycles expected; generous margin on top
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule // tb
